// >>> bench/pin_mux_status_chk.sv
`timescale 1ns/100ps
`default_nettype none
// ***
// checker
// ***
module pin_mux_status_chk
    import pin_mux_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [DATA_W-1:0] reg_rdata,
    input  wire pin_inputs_t       pin_src,
    input  wire logic              search_busy,
    input  wire logic              search_done,
    input  wire logic [7:0]        search_band,
    input  wire logic              lock_serial_out_pin_o,
    input  wire logic              lock_serial_out_pin_oe,
    input  wire logic              pullup_stage_off,
    input  wire logic              pulldown_stage_off
);
    logic [2:0] up_cnt;
    logic [7:0] band_q;
    logic [9:0] ctrl_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    always_ff @(posedge mclk) begin
        if (rst) begin
            up_cnt <= 3'h0;
            band_q <= BAND_RESET;
            ctrl_q <= 10'h001;
        end else begin
            if (up_cnt != 3'h4) up_cnt <= up_cnt + 3'h1;
            if (search_done) band_q <= search_band;
            if (reg_wr && reg_addr == OFS_PIN_SRC) ctrl_q <= reg_wdata[9:0];
        end
    end
    sequence s_rd_stat;
        reg_rd && reg_addr == OFS_BAND_STAT;
    endsequence
    sequence s_rd_ctrl;
        reg_rd && reg_addr == OFS_PIN_SRC;
    endsequence
    a_busy_mirror: assert property (s_rd_stat ##0 !$past(rst)
        |=> reg_rdata[BUSY_BIT] == $past(search_busy, 2)) else $error("busy");
    a_band_read: assert property (s_rd_stat
        |=> reg_rdata[7:0] == $past(band_q)) else $error("band value");
    a_stat_upper: assert property (s_rd_stat
        |=> reg_rdata[23:9] == 15'h0000) else $error("status upper bits");
    a_ctrl_read: assert property (s_rd_ctrl
        |=> reg_rdata[9:0] == $past(ctrl_q)) else $error("control value");
    a_ctrl_upper: assert property (s_rd_ctrl
        |=> reg_rdata[23:10] == 14'h0000) else $error("control upper bits");
    a_oe_read: assert property (up_cnt == 3'h4
        && $past(pin_src.serial_read_active, 3)
        && $past(pin_src.serial_read_active, 4)
        |-> lock_serial_out_pin_oe) else $error("driver off in read");
    a_rdata_holds: assert property (up_cnt != 3'h0
        && !$past(reg_rd) |-> $stable(reg_rdata)) else $error("rdata moved");
    a_reset_clear: assert property (disable iff (1'b0) rst
        |=> !lock_serial_out_pin_oe && reg_rdata == 24'h000000)
        else $error("reset state");
endmodule
bind pin_mux_status pin_mux_status_chk i_chk (.*);
`default_nettype wire

// >>> bench/serial_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ***
// host register side
// ***
module serial_host_model
    import pin_mux_pkg::*;
(
    input  wire logic              mclk,
    output logic      [ADDR_W-1:0] reg_addr,
    output logic      [DATA_W-1:0] reg_wdata,
    output logic                   reg_wr,
    output logic                   reg_rd,
    input  wire logic [DATA_W-1:0] reg_rdata
);
    initial begin
        reg_addr = 5'h00;
        reg_wdata = 24'h000000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task automatic wr(input logic [4:0] a, input logic [23:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d & 24'hFFFCFF;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_wdata <= ~reg_wdata;
    endtask
    task automatic rd(input logic [4:0] a, output logic [23:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// >>> bench/tb_pin_mux_status.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
// ***
// bench
// ***
module tb_pin_mux_status
    import pin_mux_pkg::*;
;
    logic              mclk = 1'b0;
    logic              rst = 1'b1;
    pin_inputs_t       pin_src = 28'h0000000;
    logic              search_busy = 1'b0;
    logic              search_done = 1'b0;
    logic [7:0]        search_band = 8'h00;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    logic              lock_serial_out_pin_o;
    logic              lock_serial_out_pin_oe;
    logic              pullup_stage_off;
    logic              pulldown_stage_off;
    logic [23:0]       rd_v;
    int                err_count = 0;
    int                n_tests = 0;
    pin_mux_status     i_dut (.*);
    serial_host_model  i_host (.*);
    always #25 mclk = ~mclk;
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic settle;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
    endtask
    function automatic int src_idx(input int c);
        if (c >= 1 && c <= 6) return 28 - c;
        if (c >= 8 && c <= 25) return 29 - c;
        if (c >= 30) return 33 - c;
        return 28;
    endfunction
    task automatic t_reset;
        i_host.rd(OFS_PIN_SRC, rd_v);
        `CHK(rd_v, 24'h000001)
        i_host.rd(OFS_BAND_STAT, rd_v);
        `CHK(rd_v, 24'h000020)
        @(negedge mclk);
        `CHK(lock_serial_out_pin_oe, 1'b0)
        `CHK({pulldown_stage_off, pullup_stage_off}, 2'b00)
        $display("reset test done");
    endtask
    task automatic t_sel;
        logic [27:0] oh;
        logic [23:0] ctl;
        for (int c = 0; c < 32; c++) begin
            oh = 28'h0000001 << src_idx(c);
            ctl = 24'h0000C0 | 24'(c);
            i_host.wr(OFS_PIN_SRC, ctl | {18'h00000, c == 0, 5'h00});
            pin_src <= oh;
            settle();
            `CHK(lock_serial_out_pin_o, c == 0 || oh != 0)
            i_host.wr(OFS_PIN_SRC, ctl);
            pin_src <= ~oh & 28'hFFFFFFC;
            settle();
            `CHK(lock_serial_out_pin_o, 1'b0)
        end
        `CHK(lock_serial_out_pin_oe, 1'b1)
        $display("selector test done");
    endtask
    task automatic t_mux;
        i_host.wr(OFS_PIN_SRC, 24'h000000);
        pin_src <= 28'h0000003;
        settle();
        `CHK({lock_serial_out_pin_o, lock_serial_out_pin_oe}, 2'b11)
        @(posedge mclk) pin_src <= 28'h0000000;
        settle();
        `CHK(lock_serial_out_pin_oe, 1'b0)
        i_host.wr(OFS_PIN_SRC, 24'h000040);
        pin_src <= 28'h0000003;
        settle();
        `CHK({lock_serial_out_pin_o, lock_serial_out_pin_oe}, 2'b01)
        i_host.rd(OFS_PIN_SRC, rd_v);
        `CHK(rd_v, 24'h000040)
        `CHK({pulldown_stage_off, pullup_stage_off}, 2'b00)
        $display("automux test done");
    endtask
    task automatic t_stat;
        @(posedge mclk) search_busy <= 1'b1;
        i_host.rd(OFS_BAND_STAT, rd_v);
        `CHK(rd_v[BUSY_BIT], 1'b1)
        @(posedge mclk) search_busy <= 1'b0;
        search_done <= 1'b1;
        search_band <= 8'hFF;
        @(posedge mclk) search_done <= 1'b0;
        search_band <= 8'h00;
        i_host.wr(OFS_BAND_STAT, 24'h000011);
        i_host.rd(OFS_BAND_STAT, rd_v);
        `CHK(rd_v, 24'h0000FF)
        i_host.rd(5'h11, rd_v);
        `CHK(rd_v, 24'h000000)
        $display("status test done");
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_sel();
        t_mux();
        t_stat();
        @(posedge mclk);
        rst <= 1'b1;
        pin_src <= 28'h0000000;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        wrap_up();
    end
    initial begin
        #250000;
        err_count++;
        wrap_up();
    end
endmodule
`default_nettype wire

// >>> inc/pin_mux_pkg.sv
package pin_mux_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam int         ADDR_W         = 5;
    localparam int         DATA_W         = 24;
    localparam logic [4:0] OFS_PIN_SRC    = 5'h0F;
    localparam logic [4:0] OFS_BAND_STAT  = 5'h10;

    // ****************************************************************
    // field positions and reset values
    // ****************************************************************
    localparam int          SEL_LSB       = 0;
    localparam int          SEL_W         = 5;
    localparam int          TEST_BIT      = 5;
    localparam int          INHIBIT_BIT   = 6;
    localparam int          HOLD_ON_BIT   = 7;
    localparam int          PULLUP_BIT    = 8;
    localparam int          PULLDOWN_BIT  = 9;
    localparam int          BUSY_BIT      = 8;
    localparam logic [4:0]  SEL_RESET     = 5'h01;
    localparam logic [7:0]  BAND_RESET    = 8'h20;
    localparam int          SYNC_STAGES   = 2;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic lock_out;
        logic lock_trigger;
        logic lock_window;
        logic ring_osc;
        logic cycle_slip_guard_up;
        logic cycle_slip_guard_dn;
        logic ref_buffer;
        logic ref_divider;
        logic osc_divider;
        logic delta_sigma_modulator_clk;
        logic aux_clock;
        logic aux_serial_clk;
        logic aux_serial_en;
        logic aux_serial_data;
        logic phase_det_dn;
        logic phase_det_up;
        logic modulator_clk_delay;
        logic modulator_core_clk;
        logic int_write_strobe;
        logic frac_write_strobe;
        logic aux_serial_strobe;
        logic serial_latch_en;
        logic divider_sync_reset;
        logic seed_load_strobe;
        logic serial_out_buf_en;
        logic soft_reset_low;
        logic serial_read_active;
        logic serial_read_out;
    } pin_inputs_t;

    typedef struct packed {
        logic [4:0] sel;
        logic       test_data;
        logic       automux_inhibit;
        logic       pin_driver_hold_on;
        logic       pullup_stage_off;
        logic       pulldown_stage_off;
    } pin_ctrl_t;

    typedef struct packed {
        logic       band_search_busy;
        logic [7:0] band;
    } band_stat_t;

endpackage

// >>> rtl/pin_mux_status.sv
`timescale 1ns/100ps
`default_nettype none
module pin_mux_status
    import pin_mux_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    input  wire pin_inputs_t       pin_src,
    input  wire logic              search_busy,
    input  wire logic              search_done,
    input  wire logic [7:0]        search_band,
    output logic                   lock_serial_out_pin_o,
    output logic                   lock_serial_out_pin_oe,
    output logic                   pullup_stage_off,
    output logic                   pulldown_stage_off
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        pin_ctrl_t         ctrl;
        band_stat_t        stat;
        logic [DATA_W-1:0] rdata;
        logic              pin;
        logic              oe;
    } top_state_t;

    top_state_t  state_reg;
    top_state_t  state_next;
    pin_inputs_t src;
    logic        gpo;

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    sync_stages #(
        .W ($bits(pin_inputs_t))
    ) u_sync (
        .mclk (mclk),
        .rst  (rst),
        .din  (pin_src),
        .dout (src)
    );

    // ****************************************************************
    // source selection
    // ****************************************************************
    always_comb begin
        unique case (state_reg.ctrl.sel)
            5'h00: gpo = state_reg.ctrl.test_data;
            5'h01: gpo = src.lock_out;
            5'h02: gpo = src.lock_trigger;
            5'h03: gpo = src.lock_window;
            5'h04: gpo = src.ring_osc;
            5'h05: gpo = src.cycle_slip_guard_up;
            5'h06: gpo = src.cycle_slip_guard_dn;
            5'h07: gpo = 1'b0;
            5'h08: gpo = src.ref_buffer;
            5'h09: gpo = src.ref_divider;
            5'h0A: gpo = src.osc_divider;
            5'h0B: gpo = src.delta_sigma_modulator_clk;
            5'h0C: gpo = src.aux_clock;
            5'h0D: gpo = src.aux_serial_clk;
            5'h0E: gpo = src.aux_serial_en;
            5'h0F: gpo = src.aux_serial_data;
            5'h10: gpo = src.phase_det_dn;
            5'h11: gpo = src.phase_det_up;
            5'h12: gpo = src.modulator_clk_delay;
            5'h13: gpo = src.modulator_core_clk;
            5'h14: gpo = src.int_write_strobe;
            5'h15: gpo = src.frac_write_strobe;
            5'h16: gpo = src.aux_serial_strobe;
            5'h17: gpo = src.serial_latch_en;
            5'h18: gpo = src.divider_sync_reset;
            5'h19: gpo = src.seed_load_strobe;
            5'h1A: gpo = 1'b0;
            5'h1B: gpo = 1'b0;
            5'h1C: gpo = 1'b0;
            5'h1D: gpo = 1'b0;
            5'h1E: gpo = src.serial_out_buf_en;
            5'h1F: gpo = src.soft_reset_low;
        endcase
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        state_next = state_reg;
        if (reg_wr && reg_addr == OFS_PIN_SRC) begin
            state_next.ctrl.sel =
                reg_wdata[SEL_LSB +: SEL_W];
            state_next.ctrl.test_data = reg_wdata[TEST_BIT];
            state_next.ctrl.automux_inhibit = reg_wdata[INHIBIT_BIT];
            state_next.ctrl.pin_driver_hold_on = reg_wdata[HOLD_ON_BIT];
            state_next.ctrl.pullup_stage_off = reg_wdata[PULLUP_BIT];
            state_next.ctrl.pulldown_stage_off = reg_wdata[PULLDOWN_BIT];
        end
        // band code 0 is the fastest band, as delivered by the search
        if (search_done) begin
            state_next.stat.band = search_band;
        end
        state_next.stat.band_search_busy = search_busy;
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_PIN_SRC: state_next.rdata =
                    {{(DATA_W - 10){1'b0}}, state_reg.ctrl.pulldown_stage_off,
                     state_reg.ctrl.pullup_stage_off,
                     state_reg.ctrl.pin_driver_hold_on,
                     state_reg.ctrl.automux_inhibit,
                     state_reg.ctrl.test_data, state_reg.ctrl.sel};
                OFS_BAND_STAT: state_next.rdata =
                    {{(DATA_W - 9){1'b0}}, state_reg.stat};
                default: state_next.rdata = '0;
            endcase
        end
        if (!state_reg.ctrl.automux_inhibit && src.serial_read_active) begin
            state_next.pin = src.serial_read_out;
        end else begin
            state_next.pin = gpo;
        end
        state_next.oe = state_reg.ctrl.pin_driver_hold_on
                      | src.serial_read_active;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg                  <= '0;
            state_reg.ctrl.sel         <= SEL_RESET;
            state_reg.stat.band        <= BAND_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign reg_rdata              = state_reg.rdata;
    assign lock_serial_out_pin_o  = state_reg.pin;
    assign lock_serial_out_pin_oe = state_reg.oe;
    assign pullup_stage_off       = state_reg.ctrl.pullup_stage_off;
    assign pulldown_stage_off     = state_reg.ctrl.pulldown_stage_off;

endmodule
`default_nettype wire

// >>> rtl/sync_stages.sv
`timescale 1ns/100ps
`default_nettype none
module sync_stages
    import pin_mux_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    // ****************************************************************
    // two flop synchroniser
    // ****************************************************************
    typedef struct packed {
        logic [W-1:0] first;
        logic [W-1:0] second;
    } sync_state_t;

    sync_state_t state_reg;
    sync_state_t state_next;

    always_comb begin
        state_next.first  = din;
        state_next.second = state_reg.first;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign dout = state_reg.second;

endmodule
`default_nettype wire
